// file: shared/sramc_consts.svh
`ifndef SRAMC_CONSTS_SVH
`define SRAMC_CONSTS_SVH

// Memory organisation.
`define SRAMC_ADDR_W        10
`define SRAMC_DATA_W        4
`define SRAMC_WORDS         1024

// Resume wait after retention, counted in memory cycle times.
`define SRAMC_RESUME_CYCLES 5

// Timing in ns; cycle counts derive from the 10 ns core clock.
`define SRAMC_CLK_NS        10
`define SRAMC_CYCLE_NS      450
`define SRAMC_STROBE_NS     200
`define SRAMC_CYCLE_CLKS    ((`SRAMC_CYCLE_NS + `SRAMC_CLK_NS - 1) / `SRAMC_CLK_NS)
`define SRAMC_STROBE_CLKS   ((`SRAMC_STROBE_NS + `SRAMC_CLK_NS - 1) / `SRAMC_CLK_NS)

`endif

// file: shared/sramc_pkg.sv
`include "sramc_consts.svh"

package sramc_pkg;

    // Pins driven toward the memory; data pins are split in/out/enable.
    typedef struct packed {
        logic [`SRAMC_ADDR_W-1:0] word_index;
        logic                     dev_en_n;
        logic                     write_n;
        logic                     out_en_n;
        logic [`SRAMC_DATA_W-1:0] data_pins_out;
        logic                     data_pins_oe;
    } sramc_pins_t;

    // One user request.
    typedef struct packed {
        logic                     write;
        logic [`SRAMC_ADDR_W-1:0] addr;
        logic [`SRAMC_DATA_W-1:0] wdata;
    } sramc_req_t;

    typedef enum logic [5:0] {
        SRAMC_IDLE    = 6'b000001,
        SRAMC_SETUP   = 6'b000010,
        SRAMC_STROBE  = 6'b000100,
        SRAMC_RECOVER = 6'b001000,
        SRAMC_RETAIN  = 6'b010000,
        SRAMC_RESUME  = 6'b100000
    } sramc_state_t;

endpackage

// file: verilog/sramc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Loadable down counter; done is high while the count is zero.
module sramc_timer
    import sramc_pkg::*;
#(
    parameter int W = 12
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] count;
    } sramc_tmr_t;

    sramc_tmr_t cur;
    sramc_tmr_t next_cur;

    // Load wins over counting so a new interval always starts cleanly.
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.count = value;
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - W'(1);
        end
    end

    // State holds while the clock enable is low.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign done = (cur.count == '0);
endmodule // sramc_timer

`default_nettype wire

// file: verilog/sramc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Index held steady through whole write.
// - Strobe high whenever index changes.
// - Early write: strobe low before enable falls.
// - Enable and strobe high around retention.
// - Five cycle times after retention exit.
module sramc_host
    import sramc_pkg::*;
#(
    parameter int ADDR_W = `SRAMC_ADDR_W,
    parameter int DATA_W = `SRAMC_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    input  wire logic              retain_req,
    output logic                   retain_active,
    output logic [ADDR_W-1:0]      word_index,
    output logic                   dev_en_n,
    output logic                   write_n,
    output logic                   out_en_n,
    output logic [DATA_W-1:0]      data_pins_out,
    output logic                   data_pins_oe,
    input  wire logic [DATA_W-1:0] data_pins_in
);
    localparam int TW = 12;
    localparam logic [TW-1:0] STROBE_LEN = TW'(`SRAMC_STROBE_CLKS);
    localparam logic [TW-1:0] CYCLE_LEN  = TW'(`SRAMC_CYCLE_CLKS);
    localparam logic [TW-1:0] RESUME_LEN = TW'(`SRAMC_CYCLE_CLKS * `SRAMC_RESUME_CYCLES);

    typedef struct packed {
        sramc_state_t      state;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              rsp;
        logic              dev_en_n;
        logic              write_n;
        logic              out_en_n;
        logic              drive;
    } sramc_host_st_t;

    sramc_host_st_t cur;
    sramc_host_st_t next_cur;
    logic           tmr_load;
    logic [TW-1:0]  tmr_value;
    logic           tmr_done;

    // One timer paces strobe width, cycle recovery and the resume wait.
    sramc_timer #(
        .W (TW)
    ) u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .load     (tmr_load),
        .value    (tmr_value),
        .done     (tmr_done)
    );

    // Access sequencer. The index is only moved in IDLE, where the strobe
    // is always high, so an unintended location can never be written.
    always_comb begin
        next_cur     = cur;
        next_cur.rsp = 1'b0;
        tmr_load     = 1'b0;
        tmr_value    = '0;
        case (cur.state)
            SRAMC_IDLE: begin
                next_cur.dev_en_n = 1'b1;
                next_cur.write_n  = 1'b1;
                next_cur.out_en_n = 1'b1;
                next_cur.drive    = 1'b0;
                if (retain_req) begin
                    next_cur.state = SRAMC_RETAIN;
                end else if (req_valid) begin
                    next_cur.write = req_write;
                    next_cur.addr  = req_addr;
                    next_cur.wdata = req_wdata;
                    next_cur.state = SRAMC_SETUP;
                end
            end
            SRAMC_SETUP: begin
                // Early write: strobe falls a cycle before enable does.
                if (cur.write) begin
                    next_cur.write_n = 1'b0;
                    next_cur.drive   = 1'b1;
                end else begin
                    next_cur.out_en_n = 1'b0;
                end
                next_cur.state = SRAMC_STROBE;
            end
            SRAMC_STROBE: begin
                next_cur.dev_en_n = 1'b0;
                if (cur.dev_en_n) begin
                    tmr_load  = 1'b1;
                    tmr_value = cur.write ? STROBE_LEN : CYCLE_LEN;
                end else if (tmr_done) begin
                    // Sample at the end of the full read window.
                    if (!cur.write) begin
                        next_cur.rdata = data_pins_in;
                        next_cur.rsp   = 1'b1;
                    end
                    next_cur.dev_en_n = 1'b1;
                    next_cur.write_n  = 1'b1;
                    next_cur.out_en_n = 1'b1;
                    tmr_load          = 1'b1;
                    tmr_value         = cur.write ? (CYCLE_LEN - STROBE_LEN) : TW'(1);
                    next_cur.state    = SRAMC_RECOVER;
                end
            end
            SRAMC_RECOVER: begin
                // Data held past strobe rise, index held until here.
                next_cur.drive = 1'b0;
                if (tmr_done) begin
                    next_cur.state = SRAMC_IDLE;
                end
            end
            SRAMC_RETAIN: begin
                next_cur.dev_en_n = 1'b1;
                next_cur.write_n  = 1'b1;
                if (!retain_req) begin
                    tmr_load       = 1'b1;
                    tmr_value      = RESUME_LEN;
                    next_cur.state = SRAMC_RESUME;
                end
            end
            SRAMC_RESUME: begin
                if (tmr_done) begin
                    next_cur.state = SRAMC_IDLE;
                end
            end
            default: begin
                next_cur.state = SRAMC_IDLE;
            end
        endcase
    end

    // All state freezes while the clock enable is low.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur          <= '0;
            cur.state    <= SRAMC_IDLE;
            cur.dev_en_n <= 1'b1;
            cur.write_n  <= 1'b1;
            cur.out_en_n <= 1'b1;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // Ready is combinational; a retention request takes priority.
    assign req_ready     = (cur.state == SRAMC_IDLE) && !retain_req && ce;
    assign rsp_valid     = cur.rsp;
    assign rsp_rdata     = cur.rdata;
    assign retain_active = (cur.state == SRAMC_RETAIN);
    assign word_index    = cur.addr;
    assign dev_en_n      = cur.dev_en_n;
    assign write_n       = cur.write_n;
    assign out_en_n      = cur.out_en_n;
    assign data_pins_out = cur.wdata;
    assign data_pins_oe  = cur.drive;
endmodule // sramc_host

`default_nettype wire

// file: testbench/sramc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level model of the 1K x 4 static memory on the host's far side.
module sramc_mem_model (
    input  wire logic [9:0] word_index,
    input  wire logic       dev_en_n,
    input  wire logic       write_n,
    input  wire logic       out_en_n,
    input  wire logic       retain,
    input  wire logic [3:0] host_d,
    input  wire logic       host_oe,
    output logic      [3:0] wire_d
);
    logic [3:0] mem [1024];
    logic [3:0] last;
    logic       drv;
    // Drive only on a read with both enables low, never in standby.
    assign drv = !dev_en_n && !out_en_n && write_n && !retain;
    // No latching: store and read follow the index level-wise.
    always @* begin
        if (!dev_en_n && !write_n && !retain) mem[word_index] = host_d;
        if (drv) last = mem[word_index];
    end
    // A released bus shows the inverse level, so a stale hold cannot pass.
    assign wire_d = host_oe ? host_d : (drv ? mem[word_index] : ~last);
endmodule // sramc_mem_model
`default_nettype wire

// file: testbench/sramc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sramc_consts.svh"
// Pin rules that the controller must keep toward the memory.
module sramc_host_properties (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic       retain_active,
    input wire logic [9:0] word_index,
    input wire logic       dev_en_n,
    input wire logic       write_n,
    input wire logic       out_en_n,
    input wire logic       data_pins_oe
);
    localparam int GAP = `SRAMC_RESUME_CYCLES * `SRAMC_CYCLE_CLKS;
    logic [8:0] since;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Cycles since standby ended; saturates so old exits never wrap.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) since <= 9'h1FF;
        else if (retain_active) since <= 9'h000;
        else if (since != 9'h1FF) since <= since + 9'h001;
    end
    sequence s_strobe; !dev_en_n && !write_n; endsequence
    sequence s_open; s_strobe ##0 $fell(dev_en_n); endsequence
    AST_EARLY: assert property (s_open |-> $past(write_n) == 1'b0)
        else $error("Enable fell before the write strobe.");
    AST_STROBE: assert property (s_open |-> s_strobe [*8])
        else $error("Write strobe window too short.");
    AST_STABLE: assert property (!write_n && $past(write_n) == 1'b0 |-> $stable(word_index))
        else $error("Index moved during a write.");
    AST_WR_DRIVE: assert property (!write_n |-> data_pins_oe && out_en_n)
        else $error("Write without host drive or with output enable low.");
    AST_NO_CLASH: assert property (!out_en_n |-> !data_pins_oe)
        else $error("Host drives while memory outputs enabled.");
    AST_RETAIN: assert property (retain_active |-> dev_en_n && write_n)
        else $error("Strobes not high in standby.");
    AST_RESUME: assert property ($fell(dev_en_n) |-> since >= GAP)
        else $error("Access too soon after standby.");
    AST_IDLE: assert property (req_ready |-> dev_en_n && write_n && !data_pins_oe)
        else $error("Pins active while idle.");
    // The answer freezes with the clock enable, so it lasts one enabled cycle.
    AST_PULSE: assert property (rsp_valid && ce |=> !rsp_valid)
        else $error("Read answer longer than one cycle.");
endmodule // sramc_host_properties
`default_nettype wire

// file: testbench/sramc_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module sramc_host_test import sramc_pkg::*;;
    logic       core_clk, rstn, ce, req_valid, req_write, retain_req;
    logic       req_ready, rsp_valid, retain_active, dev_en_n, write_n, out_en_n, data_pins_oe;
    logic [9:0] req_addr, word_index;
    logic [3:0] req_wdata, rsp_rdata, data_pins_out, wire_d;
    logic [3:0] shadow [1024];
    int         err_total, n_compared, seed, i, n;
    sramc_host dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .retain_req(retain_req), .retain_active(retain_active), .word_index(word_index),
        .dev_en_n(dev_en_n), .write_n(write_n), .out_en_n(out_en_n),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .data_pins_in(wire_d));
    sramc_mem_model mem (.word_index(word_index), .dev_en_n(dev_en_n), .write_n(write_n),
        .out_en_n(out_en_n), .retain(retain_active), .host_d(data_pins_out),
        .host_oe(data_pins_oe), .wire_d(wire_d));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Random clock-enable gaps stretch every phase of the transfer.
    always @(posedge core_clk) ce <= ($random(seed) % 8) != 0;
    function automatic logic [3:0] expect_rd(input logic [9:0] a);
        return shadow[a];
    endfunction
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Status flags and handshake outcomes; a timed-out wait shows up here.
    task automatic cmp_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %h expected %h", $time, got, exp);
        end
    endtask
    // One request held until taken; reads wait a bounded time for the answer.
    task automatic access(input logic w, input logic [9:0] a, input logic [3:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        do begin @(negedge core_clk); k++; end while (req_ready !== 1'b1 && k < 400);
        cmp_flag(req_ready, 1'b1);
        @(posedge core_clk);
        req_valid <= 1'b0;
        if (w) shadow[a] = d;
        else begin
            do begin @(negedge core_clk); k++; end while (rsp_valid !== 1'b1 && k < 400);
            cmp_flag(rsp_valid, 1'b1);
            cmp(rsp_rdata, expect_rd(a));
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        seed = 15904;
        {rstn, req_valid, req_write, retain_req} = 4'h0;
        {req_addr, req_wdata} = 14'h0000;
        {err_total, n_compared} = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        access(1'b1, 10'h000, 4'hA);
        access(1'b1, 10'h3FF, 4'h5);
        access(1'b0, 10'h000, 4'h0);
        access(1'b0, 10'h3FF, 4'h0);
        for (i = 0; i < 24; i++) begin
            n = $random(seed);
            access(1'b1, n[9:0], n[13:10]);
            access(1'b0, n[9:0], 4'h0);
        end
        @(posedge core_clk);
        retain_req <= 1'b1;
        repeat (20) @(negedge core_clk);
        cmp_flag(retain_active, 1'b1);
        cmp_flag(req_ready, 1'b0);
        @(posedge core_clk);
        retain_req <= 1'b0;
        access(1'b0, 10'h3FF, 4'h0);
        tally_and_finish();
    end
    // Cuts a hang short well beyond the expected few thousand cycles.
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end
endmodule // sramc_host_test
bind sramc_host sramc_host_properties u_props (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .retain_active(retain_active),
    .word_index(word_index), .dev_en_n(dev_en_n), .write_n(write_n),
    .out_en_n(out_en_n), .data_pins_oe(data_pins_oe));
`default_nettype wire
